// ==== design/ogb_gearbox.sv ====
`timescale 1ns/1ps
// Function
// RULE1: Each top-edge cell has one output gearbox that serializes up to eight parallel bits onto one output.
// RULE2: In seven-to-one mode the low seven input bits are shifted out on the serial output.
// RULE3: In eight-to-one double-rate mode all eight input bits go out as one serial stream.
// RULE4: In dual four-to-one mode bits three to zero feed the first lane and seven to four the second.
// RULE5: Core logic presents an eight-bit parallel word synchronous to the slow clock.
// RULE6: Three register stages sit between the parallel input and the serial output.
// RULE7: The first stage captures the parallel word on the slow clock.
// RULE8: The second stage moves the captured word into the fast domain registers.
// RULE9: The third stage, driven by the edge clock, shifts the bits out one after another.
// RULE10: Reset clears all three stages so the serial outputs sit low until new data arrives.
// RULE11: The shifting clock is one of two edge clock inputs, running at the ratio the mode needs.
module ogb_gearbox
  import ogb_pkg::*;
(
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST,
  // Configuration.
  input wire logic [1:0] MODE,
  input wire logic EDGE_CLK_SEL,
  // Edge clocks, sampled as ordinary inputs.
  input wire logic [1:0] FAST_EDGE_CLOCK,
  // Parallel side.
  input wire logic [OGB_WORD_W-1:0] PAR_DATA,
  output logic SLOW_CLK_OUT,
  output logic WORD_TAKEN,
  // Serial side.
  output logic Q,
  output logic Q_SECOND
);

  // Word length of a mode; unknown codes fall back to eight bits.
  function automatic logic [OGB_CNT_W-1:0] mode_len(input logic [1:0] m);
    logic [OGB_CNT_W-1:0] len;
    len = OGB_LEN_DDR8;
    if (m == OGB_MODE_VIDEO7) begin
      len = OGB_LEN_VIDEO7;
    end else if (m == OGB_MODE_DDR4X2) begin
      len = OGB_LEN_DDR4;
    end
    return len;
  endfunction

  // Last bit of a word; a count past the end also counts as last, so a mode change cannot strand it.
  function automatic logic word_end(input logic [OGB_CNT_W-1:0] cnt, input logic [OGB_CNT_W-1:0] len);
    return cnt >= len - OGB_CNT_ONE;
  endfunction

  function automatic logic [OGB_CNT_W-1:0] count_step(input logic [OGB_CNT_W-1:0] cnt,
                                                       input logic [OGB_CNT_W-1:0] len);
    logic [OGB_CNT_W-1:0] step;
    step = cnt + OGB_CNT_ONE;
    if (word_end(cnt, len)) begin
      step = OGB_CNT_ZERO;
    end
    return step;
  endfunction

  // One four-bit lane of the staged word, placed in the low bits of a shifter load.
  function automatic logic [OGB_WORD_W-1:0] lane_slice(input logic [OGB_WORD_W-1:0] w, input logic upper);
    logic [OGB_WORD_W-1:0] res;
    res = OGB_WORD_ZERO;
    if (upper) begin
      res[OGB_LANE_W-1:0] = w[OGB_LANE1_LSB +: OGB_LANE_W];
    end else begin
      res[OGB_LANE_W-1:0] = w[OGB_LANE0_LSB +: OGB_LANE_W];
    end
    return res;
  endfunction

  ogb_lane_if lane_a ();
  ogb_lane_if lane_b ();

  // Word position and stage registers.
  logic fast_edge_clock_r;
  logic [OGB_CNT_W-1:0] bit_cnt_r;
  logic [OGB_CNT_W-1:0] bit_cnt_nxt;
  logic slow_clk_r;
  logic slow_clk_nxt;
  logic [OGB_WORD_W-1:0] stage1_r;
  logic [OGB_WORD_W-1:0] stage2_r;
  logic taken_r;

  wire logic fast_edge_clock_pick;
  wire logic edge_evt;
  wire logic [OGB_CNT_W-1:0] len_cur;
  wire logic [OGB_CNT_W-1:0] half_cur;
  wire logic at_first;
  wire logic at_half;
  wire logic at_last;

  // Stage strobes.
  wire logic capture_evt;
  wire logic transfer_evt;
  wire logic load_evt;

  // Mode decode and shifter words.
  wire logic video;
  wire logic dual;
  wire logic [OGB_WORD_W-1:0] video_word;
  wire logic [OGB_WORD_W-1:0] low_lane_word;
  wire logic [OGB_WORD_W-1:0] high_lane_word;
  wire logic [OGB_WORD_W-1:0] word_a;
  wire logic [OGB_WORD_W-1:0] word_b;

  // RULE11 edge clock select
  assign fast_edge_clock_pick = EDGE_CLK_SEL ? FAST_EDGE_CLOCK[1] : FAST_EDGE_CLOCK[0];
  // Both edges of the edge clock move one bit, which gives double-rate output.
  assign edge_evt = fast_edge_clock_pick != fast_edge_clock_r;

  assign len_cur = mode_len(MODE);
  assign half_cur = len_cur >> 1;
  assign at_first = bit_cnt_r == OGB_CNT_ZERO;
  assign at_half = bit_cnt_r == half_cur;
  assign at_last = word_end(bit_cnt_r, len_cur);
  assign bit_cnt_nxt = count_step(bit_cnt_r, len_cur);
  assign slow_clk_nxt = bit_cnt_nxt < half_cur;

  // One strobe per stage; each fires on a bit event at its own point in the word.
  assign capture_evt = edge_evt && at_first;
  assign transfer_evt = edge_evt && at_half;
  assign load_evt = edge_evt && at_last;

  // MODE is decoded every cycle; changing it mid-stream breaks the word in flight.
  assign video = MODE == OGB_MODE_VIDEO7;
  assign dual = MODE == OGB_MODE_DDR4X2;

  // RULE2 low seven bits
  assign video_word = stage2_r & OGB_VIDEO_MASK;
  // RULE4 lane split
  assign low_lane_word = lane_slice(stage2_r, 1'b0);
  assign high_lane_word = lane_slice(stage2_r, 1'b1);
  // RULE3 full eight bits
  assign word_a = video ? video_word : dual ? low_lane_word : stage2_r;
  // The second lane shifts zeros outside the dual mode, so its pin stays low.
  assign word_b = dual ? high_lane_word : OGB_WORD_ZERO;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fast_edge_clock_r <= 1'b0;
    end else begin
      fast_edge_clock_r <= fast_edge_clock_pick;
    end
  end

  // The count moves only on bit events, so the word rate follows the edge clock.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bit_cnt_r <= OGB_CNT_ZERO;
    end else if (edge_evt) begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // The slow clock is the word rate: high for the first half of each word.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      slow_clk_r <= 1'b0;
    end else if (edge_evt) begin
      slow_clk_r <= slow_clk_nxt;
    end
  end

  // RULE6 three stages
  // RULE7 capture on slow clock
  always_ff @(posedge CORE_CLK) begin
    // RULE10 clear stage one
    if (RST) begin
      stage1_r <= OGB_WORD_ZERO;
    end else if (capture_evt) begin
      stage1_r <= PAR_DATA;
    end
  end

  // The marker is registered on the same edge as the capture, so core logic sees a clean registered pulse.
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      taken_r <= 1'b0;
    end else begin
      taken_r <= capture_evt;
    end
  end

  // RULE8 transfer to fast registers
  // The mid-word transfer keeps stage one stable while stage two samples it.
  always_ff @(posedge CORE_CLK) begin
    // RULE10 clear stage two
    if (RST) begin
      stage2_r <= OGB_WORD_ZERO;
    end else if (transfer_evt) begin
      stage2_r <= stage1_r;
    end
  end

  // RULE9 one shift per event
  // RULE1 one output gearbox
  assign lane_a.load = load_evt;
  assign lane_a.shift = edge_evt;
  assign lane_a.word = word_a;
  assign lane_b.load = load_evt;
  assign lane_b.shift = edge_evt;
  assign lane_b.word = word_b;

  ogb_lane u_lane_a (
    .clk(CORE_CLK),
    .rst(RST),
    .lif(lane_a)
  );

  ogb_lane u_lane_b (
    .clk(CORE_CLK),
    .rst(RST),
    .lif(lane_b)
  );

  assign Q = lane_a.q;
  assign Q_SECOND = lane_b.q;
  assign SLOW_CLK_OUT = slow_clk_r;
  assign WORD_TAKEN = taken_r;

endmodule

// ==== design/ogb_lane.sv ====
`timescale 1ns/1ps
module ogb_lane
  import ogb_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control side.
  ogb_lane_if.lane lif
);

  logic [OGB_WORD_W-1:0] shift_r;
  logic q_r;

  // RULE9 shift and mux
  always_ff @(posedge clk) begin
    // RULE10 clear stage three
    if (rst) begin
      shift_r <= OGB_WORD_ZERO;
      q_r <= 1'b0;
    end else if (lif.shift) begin
      if (lif.load) begin
        q_r <= lif.word[0];
        shift_r <= lif.word >> 1;
      end else begin
        q_r <= shift_r[0];
        shift_r <= shift_r >> 1;
      end
    end
  end

  assign lif.q = q_r;

endmodule

// ==== design/ogb_lane_if.sv ====
`timescale 1ns/1ps
interface ogb_lane_if;
  import ogb_pkg::*;
  logic load;
  logic shift;
  logic [OGB_WORD_W-1:0] word;
  logic q;

  modport ctrl (output load, output shift, output word, input q);
  modport lane (input load, input shift, input word, output q);
endinterface

// ==== design/ogb_pkg.sv ====
package ogb_pkg;

  // Serializer configurations selected by the MODE input.
  typedef enum logic [1:0] {
    OGB_MODE_VIDEO7,
    OGB_MODE_DDR8,
    OGB_MODE_DDR4X2
  } ogb_mode_type;

  localparam int OGB_WORD_W = 8;
  localparam int OGB_CNT_W = 4;
  localparam int OGB_LANE_W = 4;

  // Bits per word in each mode.
  localparam logic [OGB_CNT_W-1:0] OGB_LEN_VIDEO7 = 4'h7;
  localparam logic [OGB_CNT_W-1:0] OGB_LEN_DDR8 = 4'h8;
  localparam logic [OGB_CNT_W-1:0] OGB_LEN_DDR4 = 4'h4;

  localparam logic [OGB_CNT_W-1:0] OGB_CNT_ZERO = 4'h0;
  localparam logic [OGB_CNT_W-1:0] OGB_CNT_ONE = 4'h1;

  // Lane split in the dual four-to-one mode.
  localparam int OGB_LANE0_LSB = 0;
  localparam int OGB_LANE1_LSB = 4;

  localparam logic [OGB_WORD_W-1:0] OGB_WORD_ZERO = 8'h00;
  localparam logic [OGB_WORD_W-1:0] OGB_VIDEO_MASK = 8'h7f;

endpackage

// ==== verif/ogb_gearbox_assertions.sv ====
`timescale 1ns/1ps
module ogb_gearbox_assertions (
  input logic CORE_CLK,
  input logic RST,
  input logic [1:0] MODE,
  input logic EDGE_CLK_SEL,
  input logic [1:0] FAST_EDGE_CLOCK,
  input logic SLOW_CLK_OUT,
  input logic WORD_TAKEN,
  input logic Q,
  input logic Q_SECOND
);
  logic prev_r;
  wire ev = FAST_EDGE_CLOCK[EDGE_CLK_SEL] != prev_r;
  always_ff @(posedge CORE_CLK) prev_r <= RST ? 1'b0 : FAST_EDGE_CLOCK[EDGE_CLK_SEL];
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_rst; $fell(RST) |-> !(Q | Q_SECOND | WORD_TAKEN | SLOW_CLK_OUT); endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_gap; WORD_TAKEN |=> !WORD_TAKEN [*3]; endproperty
  a_gap: assert property (p_gap) else $error("gap");
  property p_two; (MODE != 2'h2) [*2] |-> !Q_SECOND; endproperty
  a_two: assert property (p_two) else $error("two");
  property p_qh; !ev |=> $stable(Q); endproperty
  a_qh: assert property (p_qh) else $error("qh");
  property p_q2h; !ev |=> $stable(Q_SECOND); endproperty
  a_q2h: assert property (p_q2h) else $error("q2h");
  property p_sh; !ev |=> $stable(SLOW_CLK_OUT); endproperty
  a_sh: assert property (p_sh) else $error("sh");
  property p_tev; WORD_TAKEN |-> $past(ev); endproperty
  a_tev: assert property (p_tev) else $error("tev");
  property p_rise; WORD_TAKEN |-> SLOW_CLK_OUT; endproperty
  a_rise: assert property (p_rise) else $error("rise");
endmodule
bind ogb_gearbox ogb_gearbox_assertions chk_u (.*);

// ==== verif/ogb_rx_model.sv ====
`timescale 1ns/1ps
module ogb_rx_model (
  input logic clk,
  input logic rst,
  input logic edge_clk,
  input logic q,
  output logic [7:0] bits
);
  logic last_r;
  // A bit is taken only on an edge clock change, since the pin holds between changes.
  always @(posedge clk) begin
    if (rst) begin
      bits <= 8'h00;
      last_r <= 1'b0;
    end else begin
      if (edge_clk != last_r) bits <= {q, bits[7:1]};
      last_r <= edge_clk;
    end
  end
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic CORE_CLK = 1'b0, RST = 1'b1, EDGE_CLK_SEL = 1'b0;
  logic [1:0] MODE = 2'h0, FAST_EDGE_CLOCK = 2'h0;
  logic [7:0] PAR_DATA = 8'h00;
  logic SLOW_CLK_OUT, WORD_TAKEN, Q, Q_SECOND;
  logic [3:0] e;
  wire [3:0] o = {Q, Q_SECOND, WORD_TAKEN, SLOW_CLK_OUT};
  logic [7:0] rx_bits;
  int error_cnt = 0, cmp_count = 0;
  integer seed = 32'h81c34499;
  always #5 CORE_CLK = ~CORE_CLK;
  ogb_gearbox dut_u (.*);
  ogb_rx_model rx_u (.clk(CORE_CLK), .rst(RST), .edge_clk(FAST_EDGE_CLOCK[EDGE_CLK_SEL]), .q(Q), .bits(rx_bits));
  task automatic tally_and_finish();
    $display("cmp %0d err %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic run(int m, int sel);
    int len = (m == 0) ? 7 : (m == 2) ? 4 : 8;
    int cnt = 0, prev = 0, s1 = 0, s2 = 0, sh = 0, ev = 0;
    logic [7:0] rx_e = 8'h00;
    MODE = 2'(m);
    EDGE_CLK_SEL = 1'(sel);
    RST = 1'b1;
    repeat (12) @(negedge CORE_CLK);
    RST = 1'b0;
    e = 4'h0;
    repeat (160) begin
      FAST_EDGE_CLOCK = FAST_EDGE_CLOCK ^ 2'($random(seed));
      PAR_DATA = 8'($random(seed));
      ev = FAST_EDGE_CLOCK[sel] != prev;
      prev = FAST_EDGE_CLOCK[sel];
      e[1] = ev && cnt == 0;
      if (e[1]) s1 = PAR_DATA;
      if (ev) begin
        if (cnt == len / 2) s2 = s1;
        if (cnt == len - 1) sh = s2;
        rx_e = {e[3], rx_e[7:1]};
        cnt = (cnt + 1) % len;
        e[0] = cnt < len / 2;
        e[3] = sh[cnt];
        e[2] = m == 2 && sh[cnt + 4];
      end
      @(negedge CORE_CLK);
      cmp_count++;
      if (o !== e) begin
        error_cnt++;
        $display("BAD outputs exp %b got %b", e, o);
      end
      cmp_count++;
      if (rx_bits !== rx_e) begin
        error_cnt++;
        $display("BAD rx_bits exp %h got %h", rx_e, rx_bits);
      end
    end
  endtask
  initial begin
    for (int k = 0; k < 8; k++) run(k / 2, k % 2);
    tally_and_finish();
  end
endmodule
